// [design/reset_ctrl.sv]
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
// How it works
// - Power-on reset restores every register
// - Bit 0 enables brownout reset monitoring
// - Sustained brownout below threshold resets system
// - Warning flag bit 3 sets while supply below warning threshold and stays set
// - Pad held high past 120us resets chip
// - Watchdog control bit 1 enables watchdog reset
// - Restart bit restarts watchdog count from zero
// - Watchdog timeout while enabled resets CPU
// - Hardware clears restart bit by itself
// - Watchdog reset sets sticky flag bit 6
// - AA then 55 unlocks watchdog control write
// - Timeout counts 32K ticks, select and fast
// - Keys 8F 32 50 in order: software reset when cause bit 5 is set
// - Flash address fault resets when enabled
// - Bit 2 reads live supply-low status
// - Address fault flag set; write 0 clears
// - Illegal program flag set; write 0 clears
// - Brownout select code passed to monitor
// - Timeout select gives 128..1024 or 8..64 ms
// - Protected registers need the key sequence
module reset_ctrl #(
    parameter int PAD_HOLD = reset_ctrl_pkg::PAD_HOLD_CYCLES
) (
    // Clock and power-on reset
    input wire logic i_clk,
    input wire logic i_reset,
    // APB slave
    input wire reset_ctrl_pkg::apb_req_t i_apb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Supply monitors and pad, asynchronous
    input wire logic i_brownout_below,
    input wire logic i_supply_warning,
    input wire logic i_reset_pad,
    // Watchdog time base and flash fault pulses
    input wire logic i_tick_32k,
    input wire logic i_flash_addr_fault,
    input wire logic i_flash_illegal_write,
    // Monitor configuration
    output logic o_brownout_enable,
    output logic [1:0] o_brownout_threshold_select,
    output logic o_warning_enable,
    output logic [1:0] o_warning_threshold_select,
    // System reset
    output logic o_system_reset
);
    logic [7:0] supply_monitor_config;
    logic [7:0] watchdog_control;
    logic [7:0] clock_select_register;
    logic [7:0] system_control_six;
    logic [7:0] unlock_key;
    logic [7:0] reset_cause_flags;
    logic prot_open;
    logic wdog_open;
    reset_ctrl_pkg::key_state_t key_state;
    reset_ctrl_pkg::key_state_t next_key_state;
    logic [15:0] wdog_count;
    logic [15:0] pad_count;
    logic [15:0] brown_count;
    logic [4:0] pulse_count;
    logic [1:0] sync_brown;
    logic [1:0] sync_warn;
    logic [1:0] sync_pad;

    // Bus decode: write commits only at the pready edge
    wire bus_access = i_apb.psel & i_apb.penable;
    wire commit_wr = bus_access & o_pready & i_apb.pwrite;
    wire [9:0] reg_idx = i_apb.paddr[11:2];
    wire [7:0] wdata = i_apb.pwdata[7:0];
    wire hit_clock = reg_idx == reset_ctrl_pkg::IDX_CLOCK_SELECT;
    wire hit_wdog = reg_idx == reset_ctrl_pkg::IDX_WATCHDOG_CONTROL;
    wire hit_key = reg_idx == reset_ctrl_pkg::IDX_UNLOCK_KEY;
    wire hit_supply = reg_idx == reset_ctrl_pkg::IDX_SUPPLY_MONITOR;
    wire hit_cause = reg_idx == reset_ctrl_pkg::IDX_RESET_CAUSE;
    wire hit_six = reg_idx == reset_ctrl_pkg::IDX_SYSTEM_CONTROL_SIX;
    wire hit_any = hit_clock | hit_wdog | hit_key | hit_supply
        | hit_cause | hit_six;
    wire wr_key = commit_wr & hit_key;
    wire wr_prot = commit_wr & prot_open & (hit_supply | hit_cause
        | hit_six);
    wire wr_wdog = commit_wr & wdog_open & hit_wdog;

    // Read mux; bit 2 of the cause register is the live status
    wire [7:0] cause_view = {reset_cause_flags[7:3], sync_warn[1],
        reset_cause_flags[1:0]};
    logic [7:0] read_byte;
    always_comb begin
        if (hit_clock) begin
            read_byte = clock_select_register;
        end else if (hit_wdog) begin
            read_byte = watchdog_control;
        end else if (hit_key) begin
            read_byte = unlock_key;
        end else if (hit_supply) begin
            read_byte = supply_monitor_config;
        end else if (hit_cause) begin
            read_byte = cause_view;
        end else if (hit_six) begin
            read_byte = system_control_six;
        end else begin
            read_byte = reset_ctrl_pkg::RST_ZERO;
        end
    end

    // Key sequencer: a wrong value drops progress, but may start anew
    wire seq_prot_done = wr_key & (key_state == reset_ctrl_pkg::KEY_GOT_P2)
        & (wdata == reset_ctrl_pkg::KEY_PROT_3);
    wire seq_wdog_done = wr_key & (key_state == reset_ctrl_pkg::KEY_GOT_W1)
        & (wdata == reset_ctrl_pkg::KEY_WDOG_2);
    always_comb begin
        next_key_state = key_state;
        if (wr_key) begin
            case (key_state)
                reset_ctrl_pkg::KEY_GOT_P1: begin
                    if (wdata == reset_ctrl_pkg::KEY_PROT_2) begin
                        next_key_state = reset_ctrl_pkg::KEY_GOT_P2;
                    end else begin
                        next_key_state = reset_ctrl_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    next_key_state = reset_ctrl_pkg::KEY_IDLE;
                end
            endcase
            if ((key_state != reset_ctrl_pkg::KEY_GOT_P1)
                    && (wdata == reset_ctrl_pkg::KEY_PROT_1)) begin
                next_key_state = reset_ctrl_pkg::KEY_GOT_P1;
            end else if (wdata == reset_ctrl_pkg::KEY_WDOG_1) begin
                next_key_state = reset_ctrl_pkg::KEY_GOT_W1;
            end
        end
    end

    // Synchronisers; only the second stage is used downstream
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            sync_brown <= 2'b00;
            sync_warn <= 2'b00;
            sync_pad <= 2'b00;
        end else begin
            sync_brown <= {sync_brown[0], i_brownout_below};
            sync_warn <= {sync_warn[0], i_supply_warning};
            sync_pad <= {sync_pad[0], i_reset_pad};
        end
    end

    // Brownout qualifying filter, only while enabled
    wire brown_on = supply_monitor_config[reset_ctrl_pkg::BROWNOUT_EN_BIT];
    wire brown_trip = brown_on & sync_brown[1] & (brown_count
        == 16'(reset_ctrl_pkg::BROWNOUT_QUAL_CYCLES));
    always_ff @(posedge i_clk) begin
        if (i_reset || !brown_on || !sync_brown[1]) begin
            brown_count <= 16'h0000;
        end else if (!brown_trip) begin
            brown_count <= brown_count + 16'h0001;
        end
    end

    // Pad filter: held high longer than the qualifying time
    wire pad_trip = sync_pad[1] & (pad_count == 16'(PAD_HOLD));
    always_ff @(posedge i_clk) begin
        if (i_reset || !sync_pad[1]) begin
            pad_count <= 16'h0000;
        end else if (!pad_trip) begin
            pad_count <= pad_count + 16'h0001;
        end
    end

    // Watchdog timeout length: base doubled once for each step of the select field
    wire [1:0] wdog_sel = clock_select_register[reset_ctrl_pkg::WDOG_SEL_LO
        +: 2];
    wire [15:0] wdog_base = clock_select_register[
        reset_ctrl_pkg::WDOG_FAST_BIT] ? reset_ctrl_pkg::WDOG_FAST_TICKS
        : reset_ctrl_pkg::WDOG_SLOW_TICKS;
    wire [15:0] wdog_limit = wdog_base << wdog_sel;
    wire wdog_on = watchdog_control[reset_ctrl_pkg::WDOG_ENABLE_BIT];
    wire wdog_restart = watchdog_control[reset_ctrl_pkg::WDOG_RESTART_BIT];
    wire wdog_trip = wdog_on & i_tick_32k
        & (wdog_count == wdog_limit - 16'h0001);
    wire addr_trip = i_flash_addr_fault & system_control_six[
        reset_ctrl_pkg::ADDR_FAULT_EN_BIT];
    wire sw_trip = seq_prot_done
        & reset_cause_flags[reset_ctrl_pkg::FLAG_SW_RESET_EN];
    wire any_trip = brown_trip | pad_trip | wdog_trip | addr_trip | sw_trip;

    // Watchdog counter on the 32K tick; restart or reset zeroes it
    always_ff @(posedge i_clk) begin
        if (i_reset || o_system_reset || wdog_restart || !wdog_on) begin
            wdog_count <= 16'h0000;
        end else if (i_tick_32k) begin
            wdog_count <= wdog_count + 16'h0001;
        end
    end

    // Reset pulse stretcher; re-armed by any new trip
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pulse_count <= 5'h00;
            o_system_reset <= 1'b1;
        end else if (any_trip) begin
            pulse_count <= 5'(reset_ctrl_pkg::RESET_PULSE_CYCLES - 1);
            o_system_reset <= 1'b1;
        end else if (pulse_count != 5'h00) begin
            pulse_count <= pulse_count - 5'h01;
        end else begin
            o_system_reset <= 1'b0;
        end
    end

    // Key state, unlock windows; each window opens one protected write
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            key_state <= reset_ctrl_pkg::KEY_IDLE;
            prot_open <= 1'b0;
            wdog_open <= 1'b0;
            unlock_key <= reset_ctrl_pkg::RST_ZERO;
        end else begin
            key_state <= next_key_state;
            if (wr_key) begin
                unlock_key <= wdata;
            end
            prot_open <= seq_prot_done | (prot_open & ~wr_prot
                & ~(wr_key));
            wdog_open <= seq_wdog_done | (wdog_open & ~wr_wdog
                & ~(wr_key));
        end
    end

    // Configuration registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            supply_monitor_config <= reset_ctrl_pkg::RST_SUPPLY_MONITOR;
            clock_select_register <= reset_ctrl_pkg::RST_CLOCK_SELECT;
            system_control_six <= reset_ctrl_pkg::RST_SYSTEM_CONTROL_SIX;
        end else begin
            if (wr_prot && hit_supply) begin
                supply_monitor_config <= wdata;
            end
            if (commit_wr && hit_clock) begin
                clock_select_register <= wdata;
            end
            if (wr_prot && hit_six) begin
                system_control_six <= wdata;
            end
        end
    end

    // Watchdog control; restart bit self-clears after one cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            watchdog_control <= reset_ctrl_pkg::RST_ZERO;
        end else if (wr_wdog) begin
            watchdog_control <= wdata;
        end else begin
            watchdog_control[reset_ctrl_pkg::WDOG_RESTART_BIT] <= 1'b0;
        end
    end

    // Cause flags: hardware set wins over a same-cycle write of 0
    logic [7:0] next_flags;
    always_comb begin
        next_flags = reset_cause_flags;
        if (wr_prot && hit_cause) begin
            next_flags = reset_cause_flags & wdata;
            next_flags[reset_ctrl_pkg::FLAG_SW_RESET_EN] =
                wdata[reset_ctrl_pkg::FLAG_SW_RESET_EN];
        end
        next_flags[7] = 1'b0;
        next_flags[reset_ctrl_pkg::FLAG_SUPPLY_LOW] = 1'b0;
        if (wdog_trip) begin
            next_flags[reset_ctrl_pkg::FLAG_WATCHDOG] = 1'b1;
        end
        if (brown_trip) begin
            next_flags[reset_ctrl_pkg::FLAG_BROWNOUT] = 1'b1;
        end
        if (sync_warn[1]) begin
            next_flags[reset_ctrl_pkg::FLAG_WARNING] = 1'b1;
        end
        if (i_flash_addr_fault) begin
            next_flags[reset_ctrl_pkg::FLAG_ADDR_FAULT] = 1'b1;
        end
        if (i_flash_illegal_write) begin
            next_flags[reset_ctrl_pkg::FLAG_ILLEGAL_WRITE] = 1'b1;
        end
    end

    // Flags live outside the system reset; power-on clears them, and so does a write of 0
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reset_cause_flags <= reset_ctrl_pkg::RST_ZERO;
        end else begin
            reset_cause_flags <= next_flags;
        end
    end

    // APB answer: one wait state, data and error registered
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pready <= 1'b0;
            o_prdata <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= bus_access & ~o_pready;
            o_prdata <= {24'h00_0000, read_byte};
            o_pslverr <= bus_access & ~o_pready & ~hit_any;
        end
    end

    // Value the config register takes at this edge
    wire [7:0] next_cfg = (wr_prot && hit_supply) ? wdata
        : supply_monitor_config;

    // Monitor configuration outputs registered from the config field
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_brownout_enable <= 1'b1;
            o_brownout_threshold_select <= 2'b10;
            o_warning_enable <= 1'b0;
            o_warning_threshold_select <= 2'b10;
        end else begin
            o_brownout_enable <= next_cfg[reset_ctrl_pkg::BROWNOUT_EN_BIT];
            o_brownout_threshold_select <=
                next_cfg[reset_ctrl_pkg::BROWNOUT_SEL_LO +: 2];
            o_warning_enable <= next_cfg[reset_ctrl_pkg::WARNING_EN_BIT];
            o_warning_threshold_select <=
                next_cfg[reset_ctrl_pkg::WARNING_SEL_LO +: 2];
        end
    end
endmodule : reset_ctrl

// [shared/reset_ctrl_pkg.sv]
package reset_ctrl_pkg;
    // APB request as one carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_CLOCK_SELECT = 10'h08E;
    localparam logic [9:0] IDX_WATCHDOG_CONTROL = 10'h0D8;
    localparam logic [9:0] IDX_UNLOCK_KEY = 10'h0EB;
    localparam logic [9:0] IDX_SUPPLY_MONITOR = 10'h0FC;
    localparam logic [9:0] IDX_RESET_CAUSE = 10'h0FD;
    localparam logic [9:0] IDX_SYSTEM_CONTROL_SIX = 10'h0FF;

    // Reset values
    localparam logic [7:0] RST_SUPPLY_MONITOR = 8'h25;
    localparam logic [7:0] RST_CLOCK_SELECT = 8'h07;
    localparam logic [7:0] RST_SYSTEM_CONTROL_SIX = 8'hC2;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Key values
    localparam logic [7:0] KEY_PROT_1 = 8'h8F;
    localparam logic [7:0] KEY_PROT_2 = 8'h32;
    localparam logic [7:0] KEY_PROT_3 = 8'h50;
    localparam logic [7:0] KEY_WDOG_1 = 8'hAA;
    localparam logic [7:0] KEY_WDOG_2 = 8'h55;

    // Field positions
    localparam int BROWNOUT_EN_BIT = 0;
    localparam int BROWNOUT_SEL_LO = 1;
    localparam int WARNING_EN_BIT = 3;
    localparam int WARNING_SEL_LO = 4;
    localparam int WDOG_RESTART_BIT = 0;
    localparam int WDOG_ENABLE_BIT = 1;
    localparam int WDOG_FAST_BIT = 5;
    localparam int WDOG_SEL_LO = 6;
    localparam int ADDR_FAULT_EN_BIT = 2;
    localparam int FLAG_ILLEGAL_WRITE = 0;
    localparam int FLAG_ADDR_FAULT = 1;
    localparam int FLAG_SUPPLY_LOW = 2;
    localparam int FLAG_WARNING = 3;
    localparam int FLAG_BROWNOUT = 4;
    localparam int FLAG_SW_RESET_EN = 5;
    localparam int FLAG_WATCHDOG = 6;

    // Clock and timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int PAD_HOLD_NS = 120000;
    localparam int PAD_HOLD_CYCLES = (PAD_HOLD_NS * 1000 + CLK_PERIOD_PS - 1)
        / CLK_PERIOD_PS;
    localparam int BROWNOUT_QUAL_NS = 1000;
    localparam int BROWNOUT_QUAL_CYCLES =
        (BROWNOUT_QUAL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RESET_PULSE_CYCLES = 16;

    // Watchdog: 32 ticks of the 32K clock per millisecond, timeouts in ms
    localparam int TICKS_PER_MS = 32;
    localparam int WDOG_SLOW_MS = 128;
    localparam int WDOG_FAST_MS = 8;
    localparam logic [15:0] WDOG_SLOW_TICKS = 16'(WDOG_SLOW_MS * TICKS_PER_MS);
    localparam logic [15:0] WDOG_FAST_TICKS = 16'(WDOG_FAST_MS * TICKS_PER_MS);

    // Key sequencer states
    typedef enum logic [2:0] {
        KEY_IDLE = 3'b000,
        KEY_GOT_P1 = 3'b001,
        KEY_GOT_P2 = 3'b010,
        KEY_GOT_W1 = 3'b011
    } key_state_t;
endpackage : reset_ctrl_pkg

// [tb/reset_ctrl_assertions.sv]
`timescale 1ns/10ps
module reset_ctrl_assertions #(
    parameter int PAD_HOLD = 20
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Bus and monitors
    input wire reset_ctrl_pkg::apb_req_t i_apb,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_brownout_below,
    input wire logic i_reset_pad,
    // Configuration and system reset
    input wire logic o_brownout_enable,
    input wire logic [1:0] o_brownout_threshold_select,
    input wire logic o_warning_enable,
    input wire logic [1:0] o_warning_threshold_select,
    input wire logic o_system_reset
);
    localparam logic [11:0] A_WD =
        {reset_ctrl_pkg::IDX_WATCHDOG_CONTROL, 2'b00};
    localparam logic [11:0] A_SM =
        {reset_ctrl_pkg::IDX_SUPPLY_MONITOR, 2'b00};
    localparam int BQ = reset_ctrl_pkg::BROWNOUT_QUAL_CYCLES;
    logic [15:0] pad_cnt;
    logic [15:0] low_cnt;
    logic [5:0] cfg;
    logic rd_wd;
    logic wr_sm;
    logic low_run;
    // Decodes of the watched bus and of the monitor outputs
    assign cfg = {o_warning_threshold_select, o_warning_enable,
        o_brownout_threshold_select, o_brownout_enable};
    assign rd_wd = o_pready && !i_apb.pwrite && i_apb.paddr == A_WD;
    assign wr_sm = o_pready && i_apb.pwrite && i_apb.paddr == A_SM;
    assign low_run = i_brownout_below && o_brownout_enable;
    // Run lengths; raw inputs, so the bounds allow for the synchroniser
    always_ff @(posedge i_clk) begin
        pad_cnt <= (i_reset || !i_reset_pad) ? 16'h0 : pad_cnt + 16'h1;
        low_cnt <= (i_reset || !low_run) ? 16'h0 : low_cnt + 16'h1;
    end
    default clocking dc @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    AST_READY_ONE_WAIT: assert property (
        i_apb.psel && $rose(i_apb.penable) |-> !o_pready ##1 o_pready)
        else $error("pready not in second access cycle");
    AST_READY_ONE_CYCLE: assert property (o_pready |=> !o_pready)
        else $error("pready held too long");
    AST_ERR_WITH_READY: assert property (
        o_pslverr |-> o_pready && o_prdata == 32'h0)
        else $error("pslverr without pready or with data");
    AST_READ_BYTE_WIDE: assert property (
        o_pready |-> o_prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    AST_RESET_PULSE_MIN: assert property (
        $rose(o_system_reset) |-> o_system_reset[*8] ##1 o_system_reset[*8])
        else $error("system reset pulse too short");
    AST_PAD_RESET: assert property (
        pad_cnt == 16'(PAD_HOLD + 4) |-> ##[0:8] o_system_reset)
        else $error("held pad gave no reset");
    AST_BROWNOUT_RESET: assert property (
        low_cnt == 16'(BQ + 4) |-> ##[0:8] o_system_reset)
        else $error("brownout gave no reset");
    AST_CONFIG_ON_WRITE: assert property (
        $changed(cfg) && !$past(i_reset) |-> $past(wr_sm))
        else $error("monitor config moved without a write");
    AST_RESTART_SELF_CLEAR: assert property (
        rd_wd |-> o_prdata[0] == 1'b0)
        else $error("restart bit read back as one");
    cover property ($rose(o_system_reset));
    cover property (o_pslverr);
    cover property (wr_sm);
endmodule : reset_ctrl_assertions

bind reset_ctrl reset_ctrl_assertions #(.PAD_HOLD(PAD_HOLD)) chk (
    .i_clk(i_clk), .i_reset(i_reset), .i_apb(i_apb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_brownout_below(i_brownout_below), .i_reset_pad(i_reset_pad),
    .o_brownout_enable(o_brownout_enable),
    .o_brownout_threshold_select(o_brownout_threshold_select),
    .o_warning_enable(o_warning_enable),
    .o_warning_threshold_select(o_warning_threshold_select),
    .o_system_reset(o_system_reset));

// [tb/supply_side_model.sv]
`timescale 1ns/10ps
module supply_side_model #(
    parameter int TICK_DIV = 2
) (
    // Clock
    input wire logic i_clk,
    // Levels and requests from the bench
    input wire logic i_below,
    input wire logic i_warn,
    input wire logic i_pad,
    input wire logic i_tick_run,
    input wire logic i_addr_req,
    input wire logic i_ill_req,
    // Lines into the block
    output logic o_brownout_below = 1'b0,
    output logic o_supply_warning = 1'b0,
    output logic o_reset_pad = 1'b0,
    output logic o_tick_32k = 1'b0,
    output logic o_flash_addr_fault = 1'b0,
    output logic o_flash_illegal_write = 1'b0
);
    logic [7:0] div = 8'h00;
    logic addr_d = 1'b0;
    logic ill_d = 1'b0;
    // Tick is one cycle wide; a fault fires once per request edge
    always @(posedge i_clk) begin
        div <= (div == 8'(TICK_DIV - 1)) ? 8'h00 : div + 8'h01;
        addr_d <= i_addr_req;
        ill_d <= i_ill_req;
        o_tick_32k <= i_tick_run && div == 8'h00;
        o_flash_addr_fault <= i_addr_req && !addr_d;
        o_flash_illegal_write <= i_ill_req && !ill_d;
        o_brownout_below <= i_below;
        o_supply_warning <= i_warn;
        o_reset_pad <= i_pad;
    end
endmodule : supply_side_model

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
    localparam int PAD = 20;
    localparam int BQ = reset_ctrl_pkg::BROWNOUT_QUAL_CYCLES;
    localparam int WD_CYC =
        2 * reset_ctrl_pkg::WDOG_FAST_MS * reset_ctrl_pkg::TICKS_PER_MS;
    localparam logic [9:0] I_CK = reset_ctrl_pkg::IDX_CLOCK_SELECT;
    localparam logic [9:0] I_WD = reset_ctrl_pkg::IDX_WATCHDOG_CONTROL;
    localparam logic [9:0] I_UK = reset_ctrl_pkg::IDX_UNLOCK_KEY;
    localparam logic [9:0] I_SM = reset_ctrl_pkg::IDX_SUPPLY_MONITOR;
    localparam logic [9:0] I_RC = reset_ctrl_pkg::IDX_RESET_CAUSE;
    localparam logic [9:0] I_SX = reset_ctrl_pkg::IDX_SYSTEM_CONTROL_SIX;
    logic i_clk;
    logic i_reset;
    reset_ctrl_pkg::apb_req_t req;
    logic [31:0] prdata;
    logic pready, pslverr, below, warn, pad, tick, afault, illegal;
    logic c_below, c_warn, c_pad, c_tick, c_addr, c_ill;
    logic br_en, wr_en, sys_rst;
    logic [1:0] br_sel, wr_sel;
    logic [31:0] rdat;
    logic rerr;
    int n_mismatch = 0;
    int num_checks = 0;
    int k;
    // Free-running clock
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    reset_ctrl #(.PAD_HOLD(PAD)) reset_ctrl_inst (
        .i_clk(i_clk), .i_reset(i_reset), .i_apb(req), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_brownout_below(below),
        .i_supply_warning(warn), .i_reset_pad(pad), .i_tick_32k(tick),
        .i_flash_addr_fault(afault), .i_flash_illegal_write(illegal),
        .o_brownout_enable(br_en), .o_brownout_threshold_select(br_sel),
        .o_warning_enable(wr_en), .o_warning_threshold_select(wr_sel),
        .o_system_reset(sys_rst));
    supply_side_model supply_side_model_inst (
        .i_clk(i_clk), .i_below(c_below), .i_warn(c_warn), .i_pad(c_pad),
        .i_tick_run(c_tick), .i_addr_req(c_addr), .i_ill_req(c_ill),
        .o_brownout_below(below), .o_supply_warning(warn),
        .o_reset_pad(pad), .o_tick_32k(tick), .o_flash_addr_fault(afault),
        .o_flash_illegal_write(illegal));
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_reg
    task automatic check_flag(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_flag
    // One APB transfer; an idle cycle follows so psel is never set twice
    task automatic apb(input logic w, input logic [9:0] idx,
        input logic [7:0] wd);
        int i;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= {idx, 2'b00};
        req.pwdata <= {24'h0, wd};
        @(posedge i_clk);
        req.penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        rdat = prdata;
        rerr = pslverr;
        if (i == 20) begin
            n_mismatch++;
            report_and_stop();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge i_clk);
    endtask : apb
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask : wr
    task automatic rd(input logic [9:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        check_reg(rdat, {24'h0, e});
    endtask : rd
    task automatic key3();
        wr(I_UK, reset_ctrl_pkg::KEY_PROT_1);
        wr(I_UK, reset_ctrl_pkg::KEY_PROT_2);
        wr(I_UK, reset_ctrl_pkg::KEY_PROT_3);
    endtask : key3
    task automatic keyw();
        wr(I_UK, reset_ctrl_pkg::KEY_WDOG_1);
        wr(I_UK, reset_ctrl_pkg::KEY_WDOG_2);
    endtask : keyw
    // Watch a window of n cycles for any system reset
    task automatic exp_rst(input int n, input logic want);
        int i;
        logic seen;
        seen = 1'b0;
        for (i = 0; i < n; i++) begin
            @(posedge i_clk);
            if (sys_rst === 1'b1) seen = 1'b1;
        end
        check_flag(seen, want);
    endtask : exp_rst
    task automatic settle();
        int i;
        for (i = 0; i < 40 && sys_rst !== 1'b0; i++) @(posedge i_clk);
        if (i == 40) begin
            n_mismatch++;
            report_and_stop();
        end
    endtask : settle
    initial begin
        i_reset = 1'b1;
        req = '0;
        {c_below, c_warn, c_pad, c_tick, c_addr, c_ill} = 6'h0;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        c_tick <= 1'b1;
        @(posedge i_clk);
        rd(I_CK, 8'h07);
        rd(I_WD, 8'h00);
        rd(I_SM, 8'h25);
        rd(I_RC, 8'h00);
        rd(I_SX, 8'hC2);
        rd(I_UK, 8'h00);
        check_reg({26'h0, wr_sel, wr_en, br_sel, br_en}, 32'h25);
        apb(1'b0, 10'h000, 8'h00);
        check_flag(rerr, 1'b1);
        check_reg(rdat, 32'h0);
        // Protected supply config: dropped, opened, then closed again
        wr(I_SM, 8'h3B);
        rd(I_SM, 8'h25);
        key3();
        wr(I_SM, 8'h3B);
        rd(I_SM, 8'h3B);
        check_reg({26'h0, wr_sel, wr_en, br_sel, br_en}, 32'h3B);
        wr(I_SM, 8'h25);
        rd(I_SM, 8'h3B);
        // A stray key value in mid-sequence
        wr(I_UK, 8'h8F);
        wr(I_UK, 8'h32);
        wr(I_UK, 8'h11);
        wr(I_UK, 8'h50);
        wr(I_SM, 8'h25);
        rd(I_SM, 8'h3B);
        // Flash faults and supply warning flags
        c_addr <= 1'b1;
        c_ill <= 1'b1;
        c_warn <= 1'b1;
        repeat (10) @(posedge i_clk);
        c_addr <= 1'b0;
        c_ill <= 1'b0;
        rd(I_RC, 8'h0F);
        key3();
        wr(I_RC, 8'h0C);
        rd(I_RC, 8'h0C);
        c_warn <= 1'b0;
        repeat (10) @(posedge i_clk);
        rd(I_RC, 8'h08);
        key3();
        wr(I_RC, 8'h00);
        rd(I_RC, 8'h00);
        // Watchdog: locked write, fast base, restarts, then timeout
        wr(I_WD, 8'h02);
        rd(I_WD, 8'h00);
        wr(I_CK, 8'h27);
        rd(I_CK, 8'h27);
        keyw();
        wr(I_WD, 8'h02);
        rd(I_WD, 8'h02);
        for (k = 0; k < 3; k++) begin
            keyw();
            wr(I_WD, 8'h03);
            exp_rst(WD_CYC - 100, 1'b0);
        end
        exp_rst(140, 1'b1);
        keyw();
        wr(I_WD, 8'h00);
        settle();
        rd(I_RC, 8'h40);
        key3();
        wr(I_RC, 8'h00);
        rd(I_RC, 8'h00);
        // Brownout qualifies, then is ignored once disabled
        c_below <= 1'b1;
        exp_rst(BQ - 40, 1'b0);
        exp_rst(60, 1'b1);
        c_below <= 1'b0;
        settle();
        rd(I_RC, 8'h10);
        key3();
        wr(I_SM, 8'h3A);
        c_below <= 1'b1;
        exp_rst(BQ + 40, 1'b0);
        c_below <= 1'b0;
        // Flash address fault with its reset enabled
        key3();
        wr(I_SX, 8'hC6);
        rd(I_SX, 8'hC6);
        c_addr <= 1'b1;
        exp_rst(20, 1'b1);
        c_addr <= 1'b0;
        settle();
        rd(I_RC, 8'h12);
        key3();
        wr(I_SX, 8'hC2);
        // Software reset once enabled
        key3();
        wr(I_RC, 8'h20);
        key3();
        exp_rst(20, 1'b1);
        settle();
        wr(I_RC, 8'h00);
        rd(I_RC, 8'h00);
        // Pad: held press gives no reset before the hold time, then resets
        c_pad <= 1'b1;
        exp_rst(PAD - 6, 1'b0);
        exp_rst(20, 1'b1);
        c_pad <= 1'b0;
        settle();
        report_and_stop();
    end
endmodule : tb
